// >>> core/avmd_detector.sv
// picture/sound silence detector: watches blanking words, mutes outputs
// assumes pixel words arrive on mclk from the link receiver with valid/ready
// Notes on behaviour
// - blanking word equal to pattern enters mute
// - mute silences audio and blanks video
// - matching blanking word mutes once an active word has been seen, unqualified
// - qualifier active high; polarity select inverts
// - qualifier never active: no mute check
// - blanking pass-through raises false mute risk
`timescale 1ns/100ps
module avmd_detector #(
  parameter int DEPTH = avmd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // configuration straps (pins, asynchronous)
  input  wire logic               qualifier_polarity_select,
  input  wire logic               blanking_pixel_passthrough,
  input  wire logic               silence_release,
  // pixel stream from link receiver
  input  wire logic               pix_in_valid,
  output logic                    pix_in_ready,
  input  wire avmd_pkg::avmd_pix_s pix_in,
  // audio sample from link receiver
  input  wire logic [31:0]        audio_in,
  // display and audio outputs
  output avmd_pkg::avmd_pix_s     pix_out,
  output logic                    pix_out_valid,
  input  wire logic               pix_out_ready,
  output logic [31:0]             audio_out,
  // status
  output logic                    picture_sound_silence,
  output logic                    passthrough_warn
);

  // two-flop synchronisers for pin inputs
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       pol;
  logic       passthru;
  logic       release_req;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_a <= {avmd_pkg::PASSTHRU_RESET, avmd_pkg::POLARITY_RESET, 1'b0};
      sync_b <= {avmd_pkg::PASSTHRU_RESET, avmd_pkg::POLARITY_RESET, 1'b0};
    end else begin
      sync_a <= {blanking_pixel_passthrough, qualifier_polarity_select, silence_release};
      sync_b <= sync_a;
    end
  end

  assign passthru    = sync_b[2];
  assign pol         = sync_b[1];
  assign release_req = sync_b[0];

  // fifo decouples the receiver from a stalled display side
  avmd_pkg::avmd_pix_s f_data;
  logic                f_valid;
  logic                f_ready;

  avmd_fifo #(
    .WIDTH (avmd_pkg::PIX_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (pix_in_valid),
    .in_ready  (pix_in_ready),
    .in_data   (pix_in),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // output register takes a word when empty or being drained
  assign f_ready = !pix_out_valid || pix_out_ready;

  function automatic logic active_of(input logic q, input logic p);
    active_of = q ^ p;
  endfunction : active_of

  logic take;
  logic active;
  logic match;

  assign take   = f_valid && f_ready;
  assign active = active_of(f_data.pixel_valid_qualifier, pol);
  // unqualified compare: random blanking data can trip it, hence the partner
  // side should gate blanking data and pass-through should stay off
  assign match  = (f_data.rgb == avmd_pkg::SILENCE_PATTERN);

  // checking is armed only once an active period has been seen, so a link
  // that never asserts the qualifier cannot trigger mute
  logic seen_active;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_active <= 1'b0;
    end else if (take && active) begin
      seen_active <= 1'b1;
    end
  end

  avmd_pkg::avmd_state_e state;
  avmd_pkg::avmd_state_e next_state;
  logic                  hit;

  assign hit = take && !active && seen_active && match;

  always_comb begin
    next_state = state;
    case (state)
      avmd_pkg::ST_RUN: begin
        if (hit) begin
          next_state = avmd_pkg::ST_MUTE;
        end
      end
      avmd_pkg::ST_MUTE: begin
        // a fresh command wins over a release in the same cycle
        if (release_req && !hit) begin
          next_state = avmd_pkg::ST_RUN;
        end
      end
      default: next_state = avmd_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= avmd_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  logic muting;
  assign muting = (next_state == avmd_pkg::ST_MUTE);

  // video path: timing passes, colour zeroed while muted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pix_out       <= '0;
      pix_out_valid <= 1'b0;
    end else if (f_ready) begin
      pix_out_valid <= f_valid;
      if (take) begin
        pix_out.hsync                 <= f_data.hsync;
        pix_out.vsync                 <= f_data.vsync;
        pix_out.pixel_valid_qualifier <= f_data.pixel_valid_qualifier;
        pix_out.rgb                   <= muting ? 24'h000000 : f_data.rgb;
      end
    end
  end

  // audio path silenced while muted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      audio_out <= 32'h00000000;
    end else begin
      audio_out <= muting ? 32'h00000000 : audio_in;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      picture_sound_silence <= 1'b0;
      passthrough_warn      <= 1'b0;
    end else begin
      picture_sound_silence <= muting;
      passthrough_warn      <= passthru;
    end
  end

endmodule : avmd_detector

// >>> core/avmd_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and async active-high reset
`timescale 1ns/100ps
module avmd_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : avmd_fifo

// >>> core/avmd_pkg.sv
// package for the picture/sound silence detector: constants and carriers
// assumes one pixel-rate clock domain, no software-visible registers
package avmd_pkg;

  // silence command pattern seen in blanking
  localparam logic [23:0] SILENCE_PATTERN = 24'h666666;
  // config byte and its bit positions (kept for reference by pin straps)
  localparam logic [7:0]  CFG_OFFSET      = 8'h12;
  localparam int          POLARITY_BIT    = 5;
  localparam int          PASSTHRU_BIT    = 6;
  // reset values and default fifo depth
  localparam logic        POLARITY_RESET  = 1'b0;
  localparam logic        PASSTHRU_RESET  = 1'b0;
  localparam int          FIFO_DEPTH      = 4;

  // pixel word with timing
  typedef struct packed {
    logic        hsync;
    logic        vsync;
    logic        pixel_valid_qualifier;
    logic [23:0] rgb;
  } avmd_pix_s;

  localparam int PIX_W = $bits(avmd_pix_s);

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_MUTE = 2'b10
  } avmd_state_e;

endpackage : avmd_pkg

// >>> test/avmd_detector_assertions.sv
// checker for the silence detector ports
// bound to avmd_detector from the bench top file
`timescale 1ns/100ps
module avmd_detector_assertions (
  input wire logic                mclk, rst, qualifier_polarity_select,
  input wire logic                blanking_pixel_passthrough, passthrough_warn,
  input wire logic                pix_in_valid, pix_in_ready, pix_out_valid, pix_out_ready,
  input wire logic                picture_sound_silence,
  input wire avmd_pkg::avmd_pix_s pix_in, pix_out,
  input wire logic [31:0]         audio_in, audio_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic seen;
  wire logic act  = pix_in.pixel_valid_qualifier ^ qualifier_polarity_select;
  wire logic take = pix_in_valid && pix_in_ready;
  // raw pin is fine here: the bench only moves polarity inside reset
  always_ff @(posedge mclk or posedge rst)
    if (rst) seen <= 1'b0;
    else if (take && act) seen <= 1'b1;
  a_hit_mutes: assert property (seen && take && !act &&
    pix_in.rgb == avmd_pkg::SILENCE_PATTERN |-> ##[1:40] picture_sound_silence) else $error("no mute");
  a_unseen_quiet: assert property (!seen |-> !picture_sound_silence) else $error("early mute");
  a_rise_blank: assert property ($rose(picture_sound_silence) |-> pix_out_valid &&
    pix_out.rgb == 24'h0 && pix_out.pixel_valid_qualifier == qualifier_polarity_select)
    else $error("bad mute entry");
  a_mute_black: assert property (picture_sound_silence |-> pix_out.rgb == 24'h0)
    else $error("colour while muted");
  a_mute_audio: assert property (picture_sound_silence |-> audio_out == 32'h0)
    else $error("audio while muted");
  a_audio_pass: assert property (!picture_sound_silence && !$past(picture_sound_silence) &&
    !$past(rst) |-> audio_out == $past(audio_in)) else $error("audio lost");
  a_stall_hold: assert property (pix_out_valid && !pix_out_ready |=>
    pix_out_valid && $stable(pix_out)) else $error("output moved in stall");
  a_warn_follow: assert property ($rose(blanking_pixel_passthrough) |-> ##[1:4] passthrough_warn)
    else $error("no warn");
  c_blank_take: cover property (take && !act);
  c_mute: cover property ($rose(picture_sound_silence));
  c_full: cover property (!pix_in_ready);
endmodule : avmd_detector_assertions

// >>> test/avmd_detector_bench.sv
// bench for the silence detector: model feeds words, bench sinks them
// assumes avmd_pkg, avmd_fifo and avmd_detector compiled first
`timescale 1ns/100ps
module avmd_detector_bench;
  logic mclk = 1'b0, rst = 1'b1, pol = 1'b0, pass = 1'b0, rel = 1'b0, gate = 1'b0;
  logic in_valid, in_ready, out_valid, out_ready = 1'b1, sil, warn;
  logic [31:0] ain = 32'hA5C30F96, aout;
  avmd_pkg::avmd_pix_s pin, pout, last;
  int fails = 0, checks_done = 0, n_out = 0;
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) if (out_valid && out_ready) begin
    last  <= pout;
    n_out <= n_out + 1;
  end
  avmd_ser_model ser_u (.mclk, .pix_in_ready(in_ready), .gate_blank(gate), .passthru(pass),
    .polarity(pol), .pix_in_valid(in_valid), .pix_in(pin));
  avmd_detector #(.DEPTH(4)) dut_u (.mclk, .rst, .qualifier_polarity_select(pol),
    .blanking_pixel_passthrough(pass), .silence_release(rel), .pix_in_valid(in_valid),
    .pix_in_ready(in_ready), .pix_in(pin), .audio_in(ain), .pix_out(pout),
    .pix_out_valid(out_valid), .pix_out_ready(out_ready), .audio_out(aout),
    .picture_sound_silence(sil), .passthrough_warn(warn));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic avmd_pkg::avmd_pix_s px(input logic q, input logic [23:0] c);
    return '{hsync: ~q, vsync: 1'b1, pixel_valid_qualifier: q, rgb: c};
  endfunction : px
  task automatic restart(input logic p);
    rst <= 1'b1;
    pol <= p;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : restart
  task automatic settle;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  task automatic t_plain;
    restart(1'b0);
    ser_u.send(px(1'b1, 24'h666666));
    ser_u.send(px(1'b0, 24'h123456));
    settle;
    check(last, px(1'b0, 24'h123456));
    check(sil, 1'b0);
    check(aout, ain);
    $display("test plain done");
  endtask : t_plain
  task automatic t_unseen;
    restart(1'b0);
    ser_u.send(px(1'b0, 24'h666666));
    settle;
    check(sil, 1'b0);
    $display("test unseen done");
  endtask : t_unseen
  task automatic t_mute;
    restart(1'b0);
    ser_u.send(px(1'b1, 24'h0000FF));
    ser_u.send(px(1'b0, 24'h666666));
    settle;
    check(sil, 1'b1);
    check(last, px(1'b0, 24'h0));
    check(aout, 32'h0);
    ser_u.send(px(1'b1, 24'h00FF00));
    settle;
    check(last, px(1'b1, 24'h0));
    rel <= 1'b1;
    settle;
    check(sil, 1'b0);
    check(aout, ain);
    @(posedge mclk) rel <= 1'b0;
    $display("test mute done");
  endtask : t_mute
  task automatic t_pol;
    restart(1'b1);
    ser_u.send(px(1'b0, 24'h666666));
    settle;
    check(sil, 1'b0);
    ser_u.send(px(1'b1, 24'h666666));
    settle;
    check(sil, 1'b1);
    $display("test polarity done");
  endtask : t_pol
  task automatic t_gate;
    restart(1'b0);
    gate <= 1'b1;
    ser_u.send(px(1'b1, 24'h111111));
    ser_u.send(px(1'b0, 24'h666666));
    settle;
    check(sil, 1'b0);
    @(posedge mclk) pass <= 1'b1;
    ser_u.send(px(1'b0, 24'h666666));
    settle;
    check(warn, 1'b1);
    check(sil, 1'b1);
    $display("test gate done");
  endtask : t_gate
  task automatic t_fifo;
    int n;
    int base;
    restart(1'b0);
    out_ready <= 1'b0;
    n = 0;
    base = n_out;
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk);
      if (!in_ready) break;
      ser_u.send(px(1'b1, 24'(i)));
      n++;
    end
    check(in_ready, 1'b0);
    check(n >= 4, 1'b1);
    @(posedge mclk) out_ready <= 1'b1;
    repeat (2) settle;
    check(n_out - base, n);
    check(last, px(1'b1, 24'(n - 1)));
    $display("test fifo done");
  endtask : t_fifo
  task automatic results;
    if (ser_u.stuck) fails++;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    t_plain;
    t_unseen;
    t_mute;
    t_pol;
    t_gate;
    t_fifo;
    results;
  end
endmodule : avmd_detector_bench
bind avmd_detector avmd_detector_assertions chk_u (.mclk, .rst, .qualifier_polarity_select,
  .blanking_pixel_passthrough, .passthrough_warn, .pix_in_valid, .pix_in_ready,
  .pix_out_valid, .pix_out_ready, .picture_sound_silence, .pix_in, .pix_out, .audio_in,
  .audio_out);

// >>> test/avmd_ser_model.sv
// far-side serializer model: offers pixel words under valid/ready
// assumes the bench calls send and reads stuck at the end
`timescale 1ns/100ps
module avmd_ser_model (
  input  wire logic           mclk, pix_in_ready, gate_blank, passthru, polarity,
  output logic                pix_in_valid,
  output avmd_pkg::avmd_pix_s pix_in
);
  logic stuck = 1'b0;
  initial pix_in_valid = 1'b0;
  initial pix_in = '0;
  task send(input avmd_pkg::avmd_pix_s w);
    logic r;
    // settings are read after the edge so a strap changed on the previous edge is seen
    @(posedge mclk);
    if (gate_blank && !passthru && w.pixel_valid_qualifier == polarity) w.rgb = 24'h0;
    pix_in_valid <= 1'b1;
    pix_in       <= w;
    r = 1'b0;
    for (int n = 0; n < 64 && !r; n++) begin
      @(negedge mclk) r = pix_in_ready;
      @(posedge mclk);
    end
    stuck        <= stuck | !r;
    pix_in_valid <= 1'b0;
    // released bus shows the inverse, never a stale word
    pix_in       <= ~w;
  endtask : send
endmodule : avmd_ser_model
